// File: pkg/sys_cfg_pkg.sv
package sys_cfg_pkg;
  // Bus decode
  localparam logic [15:0] BANK_BASE        = 16'h0180;
  localparam logic [15:0] BANK_SPAN        = 16'h0020;
  localparam int          BUS_AW           = 16;
  // Register offsets inside the bank
  localparam logic [4:0]  OFS_SYSTEM_CONTROL  = 5'h00;
  localparam logic [4:0]  OFS_MAILBOX_CONTROL = 5'h06;
  localparam logic [4:0]  OFS_MAILBOX_IN_0    = 5'h08;
  localparam logic [4:0]  OFS_MAILBOX_IN_1    = 5'h0a;
  localparam logic [4:0]  OFS_MAILBOX_OUT_0   = 5'h0c;
  localparam logic [4:0]  OFS_MAILBOX_OUT_1   = 5'h0e;
  localparam logic [4:0]  OFS_USER_NMI_VECTOR = 5'h1a;
  localparam logic [4:0]  OFS_SYS_NMI_VECTOR  = 5'h1c;
  localparam logic [4:0]  OFS_RESET_CAUSE     = 5'h1e;
  // Storage slots of the word memory
  localparam int          MEM_WORDS        = 4;
  localparam logic [1:0]  SLOT_IN_0        = 2'h0;
  localparam logic [1:0]  SLOT_IN_1        = 2'h1;
  localparam logic [1:0]  SLOT_OUT_0       = 2'h2;
  localparam logic [1:0]  SLOT_OUT_1       = 2'h3;
  // Field positions in system_control
  localparam int          POS_DEDICATED_DEBUG_PINS  = 5;
  localparam int          POS_BOOTLOADER_ENTRY_SEEN = 4;
  localparam logic [15:0] SYSTEM_CONTROL_RW_MASK   = 16'h000f;
  // Reset values
  localparam logic [15:0] RST_SYSTEM_CONTROL  = 16'h0000;
  localparam logic [15:0] RST_MAILBOX_CONTROL = 16'h000c;
  localparam logic [15:0] RST_MAILBOX_WORD    = 16'h0000;
  localparam logic [15:0] RST_USER_NMI_VECTOR = 16'h0000;
  localparam logic [15:0] RST_SYS_NMI_VECTOR  = 16'h0000;
  localparam logic [15:0] RST_RESET_CAUSE     = 16'h0002;
endpackage

// File: hw/word_store.sv
`timescale 1ns/10ps
// Small word memory with byte-lane writes and registered read data
module word_store #(
  parameter int DEPTH = 4,
  parameter int AW    = 2
) (
  input  wire logic          core_clk_i,
  input  wire logic          rst_b_i,
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic [1:0]    wr_lane_i,
  input  wire logic [15:0]   wr_data_i,
  input  wire logic [AW-1:0] rd_addr_i,
  output logic      [15:0]   rd_data_o
);
  typedef struct packed {
    logic [DEPTH-1:0][15:0] mem;
    logic [15:0]            rd;
  } store_s;

  store_s state_ff;
  store_s nxt_state;

  // Lane-selective update, read data registered
  always_comb begin
    nxt_state    = state_ff;
    nxt_state.rd = state_ff.mem[rd_addr_i];
    if (wr_en_i) begin
      if (wr_lane_i[0]) begin
        nxt_state.mem[wr_addr_i][7:0] = wr_data_i[7:0];
      end
      if (wr_lane_i[1]) begin
        nxt_state.mem[wr_addr_i][15:8] = wr_data_i[15:8];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rd_data_o = state_ff.rd;
endmodule

// File: hw/system_config_register_bank.sv
`timescale 1ns/10ps
module system_config_register_bank
  import sys_cfg_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              brown_out_reset_b_i,
  input  wire logic              bus_en_i,
  input  wire logic              bus_wr_i,
  input  wire logic              bus_byte_i,
  input  wire logic [BUS_AW-1:0] bus_addr_i,
  input  wire logic [15:0]       bus_wdata_i,
  input  wire logic              bootloader_entry_pin_i,
  input  wire logic [15:0]       user_nmi_vector_i,
  input  wire logic [15:0]       system_nmi_vector_i,
  input  wire logic [15:0]       reset_cause_vector_i,
  output logic      [15:0]       bus_rdata_o,
  output logic                   bus_rvalid_o,
  output logic                   dedicated_debug_pins_o
);
  typedef struct packed {
    logic [1:0]  entry_sync;
    logic        entry_seen;
    logic [3:0]  ctl_low;
    logic [15:0] mbx_ctl;
    logic [15:0] user_nmi;
    logic [15:0] sys_nmi;
    logic [15:0] reset_cause;
    logic [15:0] rdata;
    logic        rvalid;
    logic        rd_mem;
  } bank_s;

  bank_s state_ff;
  bank_s nxt_state;
  logic  pins_ff;
  logic  nxt_pins;

  // Offset inside the bank, only valid when in_bank is high
  logic [4:0]  ofs;
  logic        in_bank;
  logic [1:0]  lane;
  logic [15:0] wdata;
  logic        mem_hit;
  logic        mem_wr;
  logic [1:0]  mem_slot;
  logic [15:0] mem_rdata;
  logic [15:0] system_control_view;
  logic [15:0] ctl_merged;

  // Write-enable merge for one 16-bit word
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] ln);
    merge = old;
    if (ln[0]) begin
      merge[7:0] = nw[7:0];
    end
    if (ln[1]) begin
      merge[15:8] = nw[15:8];
    end
  endfunction

  // Address decode; bit 0 only selects a byte lane
  always_comb begin
    in_bank  = (bus_addr_i >= BANK_BASE) && (bus_addr_i < BANK_BASE + BANK_SPAN);
    ofs      = {bus_addr_i[4:1], 1'b0};
    if (!bus_byte_i) begin
      lane  = 2'h3;
      wdata = bus_wdata_i;
    end else if (bus_addr_i[0]) begin
      lane  = 2'h2;
      wdata = {bus_wdata_i[7:0], 8'h00};
    end else begin
      lane  = 2'h1;
      wdata = {8'h00, bus_wdata_i[7:0]};
    end
    mem_hit  = (ofs >= OFS_MAILBOX_IN_0) && (ofs <= OFS_MAILBOX_OUT_1);
    mem_slot = ofs[2:1] ^ 2'h0;
    mem_wr   = bus_en_i && bus_wr_i && in_bank && mem_hit;
    // Lane merge kept apart; a call result cannot be part-selected
    ctl_merged = merge({12'h000, state_ff.ctl_low}, wdata, lane);
  end

  assign system_control_view = {8'h00, 2'b00, pins_ff, state_ff.entry_seen, state_ff.ctl_low};

  // Register next state; read data captured one cycle after the request
  always_comb begin
    nxt_state            = state_ff;
    nxt_state.entry_sync = {state_ff.entry_sync[0], bootloader_entry_pin_i};
    // Sticky until reset; the source pulse may be brief
    nxt_state.entry_seen = state_ff.entry_seen | state_ff.entry_sync[1];
    // Vector sources are live views of the same-clock interrupt logic
    nxt_state.user_nmi    = user_nmi_vector_i;
    nxt_state.sys_nmi     = system_nmi_vector_i;
    nxt_state.reset_cause = reset_cause_vector_i;
    nxt_state.rvalid      = bus_en_i && !bus_wr_i;
    nxt_state.rd_mem      = bus_en_i && !bus_wr_i && in_bank && mem_hit;
    nxt_state.rdata       = 16'h0000;
    if (bus_en_i && in_bank) begin
      if (bus_wr_i) begin
        unique case (ofs)
          OFS_SYSTEM_CONTROL: begin
            nxt_state.ctl_low = ctl_merged[3:0] & SYSTEM_CONTROL_RW_MASK[3:0];
          end
          OFS_MAILBOX_CONTROL: begin
            nxt_state.mbx_ctl = merge(state_ff.mbx_ctl, wdata, lane);
          end
          default: begin
          end
        endcase
      end else begin
        unique case (ofs)
          OFS_SYSTEM_CONTROL:  nxt_state.rdata = system_control_view;
          OFS_MAILBOX_CONTROL: nxt_state.rdata = state_ff.mbx_ctl;
          OFS_USER_NMI_VECTOR: nxt_state.rdata = state_ff.user_nmi;
          OFS_SYS_NMI_VECTOR:  nxt_state.rdata = state_ff.sys_nmi;
          OFS_RESET_CAUSE:     nxt_state.rdata = state_ff.reset_cause;
          default:             nxt_state.rdata = 16'h0000;
        endcase
      end
    end
  end

  // Debug-pin bit: set-only, cleared solely by brown-out reset
  always_comb begin
    nxt_pins = pins_ff;
    if (bus_en_i && bus_wr_i && in_bank && (ofs == OFS_SYSTEM_CONTROL) && lane[0] &&
        wdata[POS_DEDICATED_DEBUG_PINS]) begin
      nxt_pins = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff             <= '0;
      state_ff.ctl_low     <= RST_SYSTEM_CONTROL[3:0];
      state_ff.mbx_ctl     <= RST_MAILBOX_CONTROL;
      state_ff.user_nmi    <= RST_USER_NMI_VECTOR;
      state_ff.sys_nmi     <= RST_SYS_NMI_VECTOR;
      state_ff.reset_cause <= RST_RESET_CAUSE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Separate reset domain so ordinary resets keep the pin choice
  always_ff @(posedge core_clk_i or negedge brown_out_reset_b_i) begin
    if (!brown_out_reset_b_i) begin
      pins_ff <= RST_SYSTEM_CONTROL[POS_DEDICATED_DEBUG_PINS];
    end else begin
      pins_ff <= nxt_pins;
    end
  end

  word_store #(
    .DEPTH(MEM_WORDS),
    .AW   (2)
  ) u_mailbox_words (
    .core_clk_i(core_clk_i),
    .rst_b_i   (rst_b_i),
    .wr_en_i   (mem_wr),
    .wr_addr_i (mem_slot),
    .wr_lane_i (lane),
    .wr_data_i (wdata),
    .rd_addr_i (mem_slot),
    .rd_data_o (mem_rdata)
  );

  // Mailbox words come from the memory's own output register
  always_comb begin
    bus_rdata_o = state_ff.rd_mem ? mem_rdata : state_ff.rdata;
  end
  assign bus_rvalid_o           = state_ff.rvalid;
  assign dedicated_debug_pins_o = pins_ff;
endmodule

// File: bench/sys_cfg_chk.sv
`timescale 1ns/10ps
// Port-level watch on the configuration bank
module sys_cfg_chk
  import sys_cfg_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        rst_b_i,
  input wire logic        brown_out_reset_b_i,
  input wire logic        bus_en_i,
  input wire logic        bus_wr_i,
  input wire logic [15:0] bus_addr_i,
  input wire logic [15:0] bus_wdata_i,
  input wire logic [15:0] reset_cause_vector_i,
  input wire logic [15:0] bus_rdata_o,
  input wire logic        bus_rvalid_o,
  input wire logic        dedicated_debug_pins_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [15:0] ra_ff;
  // Address of the read answered in this cycle
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) ra_ff <= 16'h0000;
    else ra_ff <= bus_addr_i;
  end
  chk_read_answered: assert property (bus_en_i && !bus_wr_i |=> bus_rvalid_o) else $error("read unanswered");
  chk_no_stray: assert property (bus_rvalid_o |-> $past(bus_en_i && !bus_wr_i)) else $error("stray answer");
  chk_ctl_reserved: assert property (bus_rvalid_o && ra_ff == BANK_BASE |-> bus_rdata_o[15:6] == 10'h000)
    else $error("reserved bits set");
  chk_pin_readback: assert property (bus_rvalid_o && ra_ff == BANK_BASE |-> bus_rdata_o[5] == $past(dedicated_debug_pins_o))
    else $error("pin bit readback wrong");
  chk_outside_zero: assert property (bus_rvalid_o && (ra_ff < BANK_BASE || ra_ff >= BANK_BASE + BANK_SPAN)
    |-> bus_rdata_o == 16'h0000) else $error("outside read not zero");
  chk_pin_set: assert property (bus_en_i && bus_wr_i && bus_addr_i == BANK_BASE && bus_wdata_i[5] && brown_out_reset_b_i
    |=> dedicated_debug_pins_o) else $error("pin bit not set");
  chk_pin_sticky: assert property ($fell(dedicated_debug_pins_o) |-> !brown_out_reset_b_i || !$past(brown_out_reset_b_i))
    else $error("pin bit cleared");
  chk_cause_live: assert property (bus_rvalid_o && ra_ff == BANK_BASE + 16'h001e && $past(rst_b_i, 2)
    |-> bus_rdata_o == $past(reset_cause_vector_i, 2)) else $error("cause vector wrong");
  cover property (bus_rvalid_o && ra_ff == BANK_BASE);
  cover property ($rose(dedicated_debug_pins_o));
  cover property (bus_en_i && bus_wr_i && bus_addr_i[0]);
endmodule
bind system_config_register_bank sys_cfg_chk i_sys_cfg_chk (.*);

// File: bench/tb.sv
`timescale 1ns/10ps
module tb
  import sys_cfg_pkg::*;
;
  logic        core_clk_i = 1'b0, rst_b_i = 1'b0, brown_out_reset_b_i = 1'b1, bootloader_entry_pin_i = 1'b0;
  logic        bus_en_i = 1'b0, bus_wr_i = 1'b0, bus_byte_i = 1'b0, bus_rvalid_o, dedicated_debug_pins_o;
  logic [15:0] bus_addr_i = 16'h0000, bus_wdata_i = 16'h0000, bus_rdata_o;
  logic [15:0] user_nmi_vector_i = 16'h0011, system_nmi_vector_i = 16'h0022, reset_cause_vector_i = 16'h0044;
  int          fails = 0, samples_checked = 0;
  system_config_register_bank i_system_config_register_bank (.*);
  // 250 MHz clock
  always #2 core_clk_i = ~core_clk_i;
  task automatic chk(input logic [15:0] s, e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // One request strobe; held until the taking edge
  task automatic acc(input logic w, b, input logic [15:0] a, d);
    @(posedge core_clk_i) #1;
    {bus_en_i, bus_wr_i, bus_byte_i, bus_addr_i, bus_wdata_i} = {1'b1, w, b, a, d};
    @(posedge core_clk_i) #1;
    bus_en_i = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, e);
    acc(1'b0, 1'b0, a, 16'h0000);
    chk({15'h0000, bus_rvalid_o}, 16'h0001);
    chk(bus_rdata_o, e);
  endtask
  // First edge after release still sees the reset-time vector
  task automatic t_reset();
    {bus_en_i, bus_addr_i} = {1'b1, BANK_BASE + 16'h001e};
    rst_b_i = 1'b1;
    @(posedge core_clk_i) #1;
    bus_en_i = 1'b0;
    chk(bus_rdata_o, RST_RESET_CAUSE);
    for (int i = 3; i < 8; i++) rd(BANK_BASE + 16'(2 * i), i == 3 ? RST_MAILBOX_CONTROL : 16'h0000);
    $display("reset test done");
  endtask
  task automatic t_lanes();
    for (int i = 3; i < 8; i++) acc(1'b1, 1'b0, BANK_BASE + 16'(2 * i), 16'h1230 + 16'(i));
    for (int i = 3; i < 8; i++) rd(BANK_BASE + 16'(2 * i), 16'h1230 + 16'(i));
    acc(1'b1, 1'b1, BANK_BASE + 16'h0009, 16'h00ab);
    rd(BANK_BASE + 16'h0008, 16'hab34);
    acc(1'b1, 1'b1, BANK_BASE + 16'h0008, 16'h00cd);
    rd(BANK_BASE + 16'h0009, 16'habcd);
    $display("lane test done");
  endtask
  // Pin bit survives a system reset but not a brown-out
  task automatic t_system_control();
    acc(1'b1, 1'b0, BANK_BASE, 16'hffdf);
    rd(BANK_BASE, 16'h000f);
    acc(1'b1, 1'b1, BANK_BASE, 16'h0020);
    rd(BANK_BASE, 16'h0020);
    acc(1'b1, 1'b0, BANK_BASE, 16'h0000);
    rst_b_i = 1'b0;
    @(posedge core_clk_i) #1;
    rst_b_i = 1'b1;
    rd(BANK_BASE, 16'h0020);
    brown_out_reset_b_i = 1'b0;
    @(posedge core_clk_i) #1;
    brown_out_reset_b_i = 1'b1;
    chk({15'h0000, dedicated_debug_pins_o}, 16'h0000);
    $display("control test done");
  endtask
  task automatic t_boot();
    bootloader_entry_pin_i = 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1 bootloader_entry_pin_i = 1'b0;
    acc(1'b1, 1'b0, BANK_BASE, 16'h0000);
    rd(BANK_BASE, 16'h0010);
    $display("bootloader test done");
  endtask
  // A hole and the reset-cause vector swallow writes
  task automatic t_holes();
    reset_cause_vector_i = 16'h0081;
    acc(1'b1, 1'b0, BANK_BASE + 16'h0002, 16'hffff);
    acc(1'b1, 1'b0, BANK_BASE + 16'h001e, 16'hffff);
    rd(BANK_BASE + 16'h0002, 16'h0000);
    rd(BANK_BASE + 16'h0020, 16'h0000);
    rd(BANK_BASE - 16'h0002, 16'h0000);
    rd(BANK_BASE + 16'h001e, 16'h0081);
    rd(BANK_BASE + 16'h001a, 16'h0011);
    rd(BANK_BASE + 16'h001c, 16'h0022);
    $display("hole test done");
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk_i);
    #1;
    t_reset();
    t_lanes();
    t_system_control();
    t_boot();
    t_holes();
    conclude();
  end
  // Hang guard
  initial begin
    #100000;
    fails++;
    conclude();
  end
endmodule
